// ---- src/t1asi_core.sv ----
// t1 line alarm detectors, latched status registers and interrupt
//
// Functional notes
// R1: flag eight consecutive zeros on both rails
// R2: flag sixteen consecutive zeros on both rails
// R3: zero-string conditions end at next one
// R4: carrier loss at 192 zeros, ends 14/112
// R5: loss-of-sync flag follows resync search
// R6: flag every codeword, decoding enabled or not
// R7: blue alarm on few zeros per 3ms
// R8: flag alignment moved by last resync
// R9: status latched until read, condition holds
// R10: interrupt low when enabled status recorded
// R11: bit2 yellow after 256 zero channels
// R12: s-bit yellow follows frame-12 s-bit
// R13: fdl yellow after sixteen clean 00ff
// R14: first mask gates line alarm status
// R15: second mask gates event status
// R16: flag severe framing event, bit 7
// R17: flag carrier restored until read
// R18: flag blue alarm cleared until read
// R19: flag frame bit errors, bit 4
// R20: saturation flags on event after saturation
// R21: framing mode bit selects yellow format
// R22: burst reads leave status unchanged
// R23: clear only after value captured
// R24: release interrupt when nothing enabled pending
`timescale 1ns/1ps
`default_nettype none
`include "t1asi_defs.svh"

module t1asi_core #(
  // blue alarm window length in system clocks
  parameter int unsigned BLUE_WIN_CYC = `T1ASI_BLUE_WIN_MS * `T1ASI_CLK_KHZ
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic line_clk_in,
  input wire logic line_positive_rail_in,
  input wire logic line_negative_rail_in,
  input wire logic framing_mode_bit_in,
  input wire logic yellow_format_bit_in,
  input wire logic resync_active_in,
  input wire logic alignment_change_in,
  input wire logic codeword_in,
  input wire logic severe_framing_in,
  input wire logic frame_bit_error_in,
  input wire logic [3:0] cnt_event_in,
  input wire logic [3:0] cnt_saturated_in,
  input wire logic chan_bit2_valid_in,
  input wire logic chan_bit2_in,
  input wire logic sbit12_valid_in,
  input wire logic sbit12_in,
  input wire logic fdl_word_valid_in,
  input wire logic [15:0] fdl_word_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_burst_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic int_n_out,
  output logic int_oe_out
);

  // last cycle of the blue window, cut to the timer width
  localparam logic [18:0] BLUE_LAST = 19'(BLUE_WIN_CYC - 1);

  t1asi_pkg::t1asi_state_t s_reg; // all core state
  t1asi_pkg::t1asi_state_t s_next; // next value of the core state

  t1asi_line_if line (); // decoded line bits from the front end

  // front end brings rails and line clock into this clock domain
  t1asi_line_front t1asi_line_front_inst (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .line_clk_in(line_clk_in),
    .line_positive_rail_in(line_positive_rail_in),
    .line_negative_rail_in(line_negative_rail_in),
    .line(line.src)
  );

  // next-state logic for detectors, registers and interrupt
  always_comb begin
    logic [7:0] ev1; // one-shot sets for the line alarm status
    logic [7:0] cond1; // live conditions that keep line bits set
    logic [7:0] ev2; // one-shot sets for the event status
    logic [7:0] clr1; // read clear for the line alarm status
    logic [7:0] clr2; // read clear for the event status
    logic [3:0] ones_now; // carrier window ones including this bit
    logic [2:0] zeros_now; // blue window zeros including this bit
    logic blue_now; // blue decision at window end
    t1asi_pkg::t1asi_yel_mode_t mode_now; // format wanted by control bits
    ev1 = '0;
    cond1 = '0;
    ev2 = '0;
    clr1 = '0;
    clr2 = '0;
    ones_now = s_reg.cl_ones;
    zeros_now = s_reg.blue_zeros;
    blue_now = s_reg.blue;
    mode_now = t1asi_pkg::T1ASI_YEL_BIT2;
    s_next = s_reg;

    // zero-run length, saturating, restarted by any mark
    if (line.bit_valid) begin
      if (line.bit_one) begin
        s_next.zero_run = '0; // [R3]
      end else if (s_reg.zero_run != `T1ASI_ZERO_RUN_MAX) begin
        s_next.zero_run = s_reg.zero_run + 8'h01;
      end
    end
    // zero-string conditions follow the run length
    cond1[`T1ASI_B1_EIGHT_ZERO] = (s_next.zero_run >= `T1ASI_EIGHT_ZEROS); // [R1] [R3]
    cond1[`T1ASI_B1_SIXTEEN_ZERO] = (s_next.zero_run >= `T1ASI_SIXTEEN_ZEROS); // [R2] [R3]

    // carrier loss: declare on long run, then judge 112-bit windows
    if (!s_reg.carrier_loss) begin
      if (s_next.zero_run >= `T1ASI_CL_ZEROS) begin
        s_next.carrier_loss = 1'b1; // [R4]
        s_next.cl_ones = '0;
        s_next.cl_win = '0;
      end
    end else if (line.bit_valid) begin
      // count marks, capped at the threshold
      if (line.bit_one && s_reg.cl_ones != `T1ASI_CL_ONES) begin
        ones_now = s_reg.cl_ones + 4'h1;
      end
      if (s_reg.cl_win == `T1ASI_CL_WINDOW_LAST) begin
        // window complete: enough marks restores carrier
        if (ones_now >= `T1ASI_CL_ONES) begin
          s_next.carrier_loss = 1'b0; // [R4]
          ev2[`T1ASI_B2_CARRIER_RESTORED] = 1'b1; // [R17]
        end
        s_next.cl_ones = '0;
        s_next.cl_win = '0;
      end else begin
        s_next.cl_ones = ones_now;
        s_next.cl_win = s_reg.cl_win + 7'h01;
      end
    end
    cond1[`T1ASI_B1_CARRIER_LOSS] = s_next.carrier_loss; // [R4]

    // blue alarm: count zeros over a fixed window of system clocks
    if (line.bit_valid && !line.bit_one && s_reg.blue_zeros != `T1ASI_BLUE_ZERO_CAP) begin
      zeros_now = s_reg.blue_zeros + 3'h1;
    end
    if (s_reg.blue_timer == BLUE_LAST) begin
      // few zeros means an all-ones signal is arriving
      blue_now = (zeros_now <= `T1ASI_BLUE_MAX_ZEROS); // [R7]
      if (s_reg.blue && !blue_now) begin
        ev2[`T1ASI_B2_BLUE_CLEARED] = 1'b1; // [R18]
      end
      s_next.blue = blue_now;
      s_next.blue_zeros = '0;
      s_next.blue_timer = '0;
    end else begin
      s_next.blue_zeros = zeros_now;
      s_next.blue_timer = s_reg.blue_timer + 19'h00001;
    end
    cond1[`T1ASI_B1_BLUE] = s_next.blue; // [R7]

    // yellow alarm format chosen from framing mode and format bits
    if (framing_mode_bit_in) begin
      mode_now = t1asi_pkg::T1ASI_YEL_FDL; // [R21]
    end else if (yellow_format_bit_in) begin
      mode_now = t1asi_pkg::T1ASI_YEL_SBIT; // [R21]
    end else begin
      mode_now = t1asi_pkg::T1ASI_YEL_BIT2; // [R21]
    end

    if (mode_now != s_reg.yel_mode) begin
      // format change drops any half-built detection
      s_next.yel_mode = mode_now;
      s_next.yellow = 1'b0;
      s_next.yel_cnt = '0;
    end else begin
      unique case (s_reg.yel_mode)
        t1asi_pkg::T1ASI_YEL_BIT2: begin
          // bit 2 of every channel must stay zero
          if (chan_bit2_valid_in) begin
            if (chan_bit2_in) begin
              s_next.yellow = 1'b0; // [R11]
              s_next.yel_cnt = '0;
            end else if (s_reg.yel_cnt != `T1ASI_YEL_CHANNELS) begin
              s_next.yel_cnt = s_reg.yel_cnt + 9'h001;
              if (s_next.yel_cnt == `T1ASI_YEL_CHANNELS) begin
                s_next.yellow = 1'b1; // [R11]
              end
            end
          end
        end
        t1asi_pkg::T1ASI_YEL_SBIT: begin
          // alarm mirrors the frame-12 s-bit
          if (sbit12_valid_in) begin
            s_next.yellow = sbit12_in; // [R12]
          end
        end
        t1asi_pkg::T1ASI_YEL_FDL: begin
          // data link must repeat the pattern without a break
          if (fdl_word_valid_in) begin
            if (fdl_word_in != `T1ASI_YEL_FDL_PATTERN) begin
              s_next.yellow = 1'b0; // [R13]
              s_next.yel_cnt = '0;
            end else if (s_reg.yel_cnt[4:0] != `T1ASI_YEL_FDL_REPEATS) begin
              s_next.yel_cnt = s_reg.yel_cnt + 9'h001;
              if (s_next.yel_cnt[4:0] == `T1ASI_YEL_FDL_REPEATS) begin
                s_next.yellow = 1'b1; // [R13]
              end
            end
          end
        end
        default: begin
          // unused code: fall back to the reset format
          s_next.yel_mode = t1asi_pkg::T1ASI_YEL_BIT2;
          s_next.yellow = 1'b0;
          s_next.yel_cnt = '0;
        end
      endcase
    end
    cond1[`T1ASI_B1_YELLOW] = s_next.yellow;

    // conditions and events from the synchroniser
    cond1[`T1ASI_B1_LOSS_OF_SYNC] = resync_active_in; // [R5]
    ev1[`T1ASI_B1_CODEWORD] = codeword_in; // [R6]
    ev1[`T1ASI_B1_ALIGN_CHANGE] = alignment_change_in; // [R8]

    // framing events and counter saturation
    ev2[`T1ASI_B2_SEVERE_FRAMING] = severe_framing_in; // [R16]
    ev2[`T1ASI_B2_FRAME_BIT_ERROR] = frame_bit_error_in; // [R19]
    ev2[`T1ASI_B2_SAT_MSB:0] = cnt_event_in & cnt_saturated_in; // [R20]

    // register read: capture old value, single status reads also clear
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `T1ASI_IDX_LINE_STATUS: begin
          s_next.rd_data = s_reg.line_status; // [R23]
          if (!reg_burst_in) begin
            clr1 = '1; // [R22]
          end
        end
        `T1ASI_IDX_LINE_MASK: begin
          s_next.rd_data = s_reg.line_mask;
        end
        `T1ASI_IDX_EVENT_STATUS: begin
          s_next.rd_data = s_reg.event_status; // [R23]
          if (!reg_burst_in) begin
            clr2 = '1; // [R22]
          end
        end
        `T1ASI_IDX_EVENT_MASK: begin
          s_next.rd_data = s_reg.event_mask;
        end
        default: begin
          // unmapped address reads as zero
          s_next.rd_data = `T1ASI_UNMAPPED_DATA;
        end
      endcase
    end

    // register write: only the masks are writable
    if (reg_wr_in) begin
      if (reg_addr_in == `T1ASI_IDX_LINE_MASK) begin
        s_next.line_mask = reg_wdata_in;
      end
      if (reg_addr_in == `T1ASI_IDX_EVENT_MASK) begin
        s_next.event_mask = reg_wdata_in;
      end
    end

    // sticky status: a set or live condition wins over the clear
    s_next.line_status = (s_reg.line_status & ~clr1) | ev1 | cond1; // [R9] [R23]
    s_next.event_status = (s_reg.event_status & ~clr2) | ev2; // [R9] [R23]

    // interrupt pending while any enabled bit is set
    s_next.irq = (|(s_next.line_status & s_next.line_mask)) // [R14] [R10]
      | (|(s_next.event_status & s_next.event_mask)); // [R15] [R24]
  end

  // register the state; clock enable freezes every field
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else if (clk_en_in) begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_out = s_reg.rd_data;
  // open-drain interrupt: drive low only while pending
  assign int_n_out = ~s_reg.irq; // [R10]
  assign int_oe_out = s_reg.irq; // [R10] [R24]

endmodule

`default_nettype wire

// ---- include/t1asi_defs.svh ----
// constants for the t1 alarm, status and interrupt block
`ifndef T1ASI_DEFS_SVH
`define T1ASI_DEFS_SVH

// register indices on the serial port address field
`define T1ASI_IDX_LINE_STATUS 4'h8
`define T1ASI_IDX_LINE_MASK 4'h9
`define T1ASI_IDX_EVENT_STATUS 4'ha
`define T1ASI_IDX_EVENT_MASK 4'hb

// reset values
`define T1ASI_STATUS_RST 8'h00
`define T1ASI_MASK_RST 8'h00
`define T1ASI_UNMAPPED_DATA 8'h00

// line alarm status field positions
`define T1ASI_B1_EIGHT_ZERO 7
`define T1ASI_B1_SIXTEEN_ZERO 6
`define T1ASI_B1_CARRIER_LOSS 5
`define T1ASI_B1_YELLOW 4
`define T1ASI_B1_LOSS_OF_SYNC 3
`define T1ASI_B1_CODEWORD 2
`define T1ASI_B1_BLUE 1
`define T1ASI_B1_ALIGN_CHANGE 0

// event and saturation status field positions
`define T1ASI_B2_SEVERE_FRAMING 7
`define T1ASI_B2_CARRIER_RESTORED 6
`define T1ASI_B2_BLUE_CLEARED 5
`define T1ASI_B2_FRAME_BIT_ERROR 4
`define T1ASI_B2_SAT_MSB 3

// line bit counts
`define T1ASI_EIGHT_ZEROS 8'h08
`define T1ASI_SIXTEEN_ZEROS 8'h10
`define T1ASI_ZERO_RUN_MAX 8'hff
`define T1ASI_CL_ZEROS 8'hc0
`define T1ASI_CL_ONES 4'he
`define T1ASI_CL_WINDOW_LAST 7'h6f
`define T1ASI_BLUE_MAX_ZEROS 3'h5
`define T1ASI_BLUE_ZERO_CAP 3'h6

// blue alarm window: time in ms and clock rate in khz
`define T1ASI_BLUE_WIN_MS 3
`define T1ASI_CLK_KHZ 100000

// yellow alarm figures
`define T1ASI_YEL_CHANNELS 9'h100
`define T1ASI_YEL_FDL_REPEATS 5'h10
`define T1ASI_YEL_FDL_PATTERN 16'h00ff

`endif

// ---- include/t1asi_pkg.sv ----
// types shared by the t1 alarm, status and interrupt block
`include "t1asi_defs.svh"

package t1asi_pkg;

  // yellow alarm format, gray coded along bit2 -> s-bit -> fdl
  typedef enum logic [1:0] {
    T1ASI_YEL_BIT2 = 2'b00,
    T1ASI_YEL_SBIT = 2'b01,
    T1ASI_YEL_FDL = 2'b11
  } t1asi_yel_mode_t;

  // state of the line front end
  typedef struct packed {
    logic [1:0] pos_sync;
    logic [1:0] neg_sync;
    logic [2:0] clk_sync;
    logic bit_valid;
    logic bit_one;
  } t1asi_front_t;

  // state of the alarm and status core
  typedef struct packed {
    logic [7:0] zero_run;
    logic carrier_loss;
    logic [3:0] cl_ones;
    logic [6:0] cl_win;
    logic blue;
    logic [2:0] blue_zeros;
    logic [18:0] blue_timer;
    t1asi_yel_mode_t yel_mode;
    logic yellow;
    logic [8:0] yel_cnt;
    logic [7:0] line_status;
    logic [7:0] line_mask;
    logic [7:0] event_status;
    logic [7:0] event_mask;
    logic [7:0] rd_data;
    logic irq;
  } t1asi_state_t;

endpackage

// ---- include/t1asi_line_if.sv ----
// carrier for decoded line bits between front end and core
`timescale 1ns/1ps
`default_nettype none

interface t1asi_line_if;
  logic bit_valid; // one-cycle pulse per received line bit
  logic bit_one; // received bit was a one on either rail

  modport src (output bit_valid, output bit_one);
  modport dst (input bit_valid, input bit_one);
endinterface

`default_nettype wire

// ---- src/t1asi_line_front.sv ----
// line front end: synchronises rails and line clock, emits bit pulses
`timescale 1ns/1ps
`default_nettype none

module t1asi_line_front (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic line_clk_in,
  input wire logic line_positive_rail_in,
  input wire logic line_negative_rail_in,
  t1asi_line_if.src line
);

  t1asi_pkg::t1asi_front_t s_reg; // all front end state
  t1asi_pkg::t1asi_front_t s_next; // next value

  // shift the pins through two flops, then detect the line clock rise
  always_comb begin
    s_next = s_reg;
    s_next.pos_sync = {s_reg.pos_sync[0], line_positive_rail_in};
    s_next.neg_sync = {s_reg.neg_sync[0], line_negative_rail_in};
    s_next.clk_sync = {s_reg.clk_sync[1:0], line_clk_in};
    // only second and third stages are compared
    s_next.bit_valid = s_reg.clk_sync[1] & ~s_reg.clk_sync[2];
    // a one on either rail is a mark; zero means both rails low
    s_next.bit_one = s_reg.pos_sync[1] | s_reg.neg_sync[1];
  end

  // register the state; clock enable freezes it
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else if (clk_en_in) begin
      s_reg <= s_next;
    end
  end

  // bit strobe only lasts one enabled cycle
  assign line.bit_valid = s_reg.bit_valid & clk_en_in;
  assign line.bit_one = s_reg.bit_one;

endmodule

`default_nettype wire

// ---- sim/t1asi_host_model.sv ----
// host processor model driving the register port of the alarm core
`timescale 1ns/1ps
`default_nettype none

module t1asi_host_model (
  input wire logic clk_in,
  output logic [3:0] addr_out,
  output logic rd_out,
  output logic burst_out,
  output logic wr_out,
  output logic [7:0] wdata_out
);
  // idle port from time zero
  initial begin
    addr_out = 4'h0;
    rd_out = 1'b0;
    burst_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end

  // one read strobe, held up to its sampling edge
  task automatic rd(input logic [3:0] a, input logic b);
    @(posedge clk_in);
    addr_out <= a;
    burst_out <= b;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    burst_out <= 1'b0;
  endtask

  // one write strobe; data is scrambled once released
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
endmodule

`default_nettype wire

// ---- sim/t1asi_core_properties.sv ----
// concurrent checks on the ports of the alarm core
`timescale 1ns/1ps
`default_nettype none

module t1asi_core_properties (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic resync_active_in,
  input wire logic codeword_in,
  input wire logic severe_framing_in,
  input wire logic [3:0] cnt_event_in,
  input wire logic [3:0] cnt_saturated_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_burst_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic int_n_out,
  input wire logic int_oe_out
);
  logic [7:0] m1_reg; // shadow of the line alarm mask
  logic [7:0] m2_reg; // shadow of the event mask

  // follow mask writes as the core takes them
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      m1_reg <= 8'h00;
      m2_reg <= 8'h00;
    end else if (clk_en_in && reg_wr_in && reg_addr_in == 4'h9) begin
      m1_reg <= reg_wdata_in;
    end else if (clk_en_in && reg_wr_in && reg_addr_in == 4'hb) begin
      m2_reg <= reg_wdata_in;
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  property p_oe; int_oe_out == !int_n_out; endproperty
  a_oe: assert property (p_oe) else $error("enable disagrees with int");
  property p_cw; clk_en_in && codeword_in && m1_reg[2] |=> !int_n_out; endproperty
  a_cw: assert property (p_cw) else $error("codeword gave no int");
  property p_sev; clk_en_in && severe_framing_in && m2_reg[7] |=> !int_n_out; endproperty
  a_sev: assert property (p_sev) else $error("framing event gave no int");
  property p_sat;
    clk_en_in && cnt_event_in[0] && cnt_saturated_in[0] && m2_reg[0] |=> !int_n_out;
  endproperty
  a_sat: assert property (p_sat) else $error("saturation gave no int");
  property p_los; clk_en_in && resync_active_in && m1_reg[3] |=> !int_n_out; endproperty
  a_los: assert property (p_los) else $error("sync loss gave no int");
  property p_quiet; (m1_reg | m2_reg) == 8'h00 |-> int_n_out; endproperty
  a_quiet: assert property (p_quiet) else $error("int with all masked");
  property p_mask_rd;
    clk_en_in && reg_rd_in && reg_addr_in == 4'h9 |=> reg_rdata_out == $past(m1_reg);
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
  property p_unmapped;
    clk_en_in && reg_rd_in && reg_addr_in < 4'h8 |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold; !(clk_en_in && reg_rd_in) |=> $stable(reg_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");

  // main scenarios reached
  c_cw: cover property (codeword_in && m1_reg[2]);
  c_burst: cover property (reg_rd_in && reg_burst_in);
  c_los: cover property (resync_active_in ##1 !int_n_out);
endmodule

bind t1asi_core t1asi_core_properties t1asi_core_properties_inst (.clk_sys_in, .rst_n_in,
  .clk_en_in, .resync_active_in, .codeword_in, .severe_framing_in, .cnt_event_in,
  .cnt_saturated_in, .reg_addr_in, .reg_rd_in, .reg_burst_in, .reg_wr_in, .reg_wdata_in,
  .reg_rdata_out, .int_n_out, .int_oe_out);

`default_nettype wire

// ---- sim/t1_alarm_status_interrupt_tb_top.sv ----
// self-checking bench for the alarm, status and interrupt core
`timescale 1ns/1ps
`default_nettype none

module t1_alarm_status_interrupt_tb_top;
  logic clk_sys_in = 1'b0; // system clock
  logic rst_n_in = 1'b0; // reset, active low
  logic clk_en_in = 1'b1, line_clk_in = 1'b0; // run enable and line clock pin
  logic line_positive_rail_in = 1'b0, line_negative_rail_in = 1'b0;
  logic framing_mode_bit_in = 1'b0, yellow_format_bit_in = 1'b0, resync_active_in = 1'b0;
  logic alignment_change_in = 1'b0, codeword_in = 1'b0;
  logic severe_framing_in = 1'b0, frame_bit_error_in = 1'b0;
  logic [3:0] cnt_event_in = 4'h0, cnt_saturated_in = 4'hf;
  logic chan_bit2_valid_in = 1'b0, chan_bit2_in = 1'b0, sbit12_valid_in = 1'b0;
  logic sbit12_in = 1'b0, fdl_word_valid_in = 1'b0;
  logic [15:0] fdl_word_in = 16'h0000;
  logic [3:0] reg_addr_in; // register port, driven by the host model
  logic reg_rd_in, reg_burst_in, reg_wr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out;
  logic int_n_out, int_oe_out;
  logic rd_seen = 1'b0; // a read was taken on the last edge
  logic [15:0] note; // mask and expected value of one read
  logic [15:0] exp_q[$]; // expectations in read order
  logic [15:0] lfsr_state = 16'h90a7; // random source
  int err_count = 0, num_checks = 0;
  int ev_list[8] = '{0, 1, 2, 3, 4, 7, 8, 10}; // pulse inputs, status bit codes

  t1asi_core #(.BLUE_WIN_CYC(64)) t1asi_core_inst (.clk_sys_in, .rst_n_in, .clk_en_in,
    .line_clk_in, .line_positive_rail_in, .line_negative_rail_in, .framing_mode_bit_in,
    .yellow_format_bit_in, .resync_active_in, .alignment_change_in, .codeword_in,
    .severe_framing_in, .frame_bit_error_in, .cnt_event_in, .cnt_saturated_in,
    .chan_bit2_valid_in, .chan_bit2_in, .sbit12_valid_in, .sbit12_in, .fdl_word_valid_in,
    .fdl_word_in, .reg_addr_in, .reg_rd_in, .reg_burst_in, .reg_wr_in, .reg_wdata_in,
    .reg_rdata_out, .int_n_out, .int_oe_out);

  t1asi_host_model t1asi_host_model_inst (.clk_in(clk_sys_in), .addr_out(reg_addr_in),
    .rd_out(reg_rd_in), .burst_out(reg_burst_in), .wr_out(reg_wr_in),
    .wdata_out(reg_wdata_in));

  // 100 mhz clock
  always #5 clk_sys_in = ~clk_sys_in;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // note the expectation, then read through the host
  task automatic rd(input logic [3:0] a, input logic [7:0] e, m, input logic b = 1'b0);
    exp_q.push_back({m, e});
    t1asi_host_model_inst.rd(a, b);
  endtask

  // one event pulse; codes 8 and 10 land in the line alarm status
  task automatic pulse(input int j);
    @(posedge clk_sys_in);
    case (j)
      4: frame_bit_error_in <= 1'b1;
      7: severe_framing_in <= 1'b1;
      8: alignment_change_in <= 1'b1;
      10: codeword_in <= 1'b1;
      default: cnt_event_in[j[1:0]] <= 1'b1;
    endcase
    @(posedge clk_sys_in);
    {severe_framing_in, frame_bit_error_in, alignment_change_in, codeword_in} <= 4'h0;
    cnt_event_in <= 4'h0;
  endtask

  // n line bits, a one on a randomly chosen rail, rails steady round the clock rise
  task automatic sends(input logic b, input int n);
    repeat (n) begin
      lfsr_state = lfsr_next(lfsr_state);
      @(posedge clk_sys_in);
      line_positive_rail_in <= b & lfsr_state[0];
      line_negative_rail_in <= b & ~lfsr_state[0];
      repeat (3) @(posedge clk_sys_in);
      line_clk_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      line_clk_in <= 1'b0;
    end
  endtask

  // n yellow inputs of kind k: 0 channel bit 2, 1 frame-12 s-bit, 2 data link word
  task automatic yel(input int k, input logic v, input int n);
    repeat (n) begin
      @(posedge clk_sys_in);
      chan_bit2_valid_in <= (k == 0);
      sbit12_valid_in <= (k == 1);
      fdl_word_valid_in <= (k == 2);
      chan_bit2_in <= v;
      sbit12_in <= v;
      fdl_word_in <= v ? 16'h00ff : 16'h00fe;
      @(posedge clk_sys_in);
      {chan_bit2_valid_in, sbit12_valid_in, fdl_word_valid_in} <= 3'h0;
    end
  endtask

  // note each read taken; its answer stands from the next edge
  always @(posedge clk_sys_in) rd_seen <= reg_rd_in & clk_en_in;

  // compare each answer with the oldest note
  always @(negedge clk_sys_in) begin
    if (rd_seen === 1'b1) begin
      note = exp_q.pop_front();
      check(reg_rdata_out & note[15:8], note[7:0] & note[15:8]);
    end
  end

  // hang guard
  initial begin
    #200000;
    err_count++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00, 8'hfd);
    repeat (2) begin
      lfsr_state = lfsr_next(lfsr_state);
      t1asi_host_model_inst.wr(4'h9, lfsr_state[7:0]);
      t1asi_host_model_inst.wr(4'hb, lfsr_state[15:8]);
      rd(4'h9, lfsr_state[7:0], 8'hff);
      rd(4'hb, lfsr_state[15:8], 8'hff);
    end
    t1asi_host_model_inst.wr(4'h8, 8'hff);
    rd(4'h8, 8'h00, 8'hfd);
    t1asi_host_model_inst.wr(4'h9, 8'h0d);
    t1asi_host_model_inst.wr(4'hb, 8'h9f);
    foreach (ev_list[i]) begin
      pulse(ev_list[i]);
      rd(ev_list[i] > 7 ? 4'h8 : 4'ha, 8'h01 << ev_list[i][2:0], 8'h9d);
      rd(ev_list[i] > 7 ? 4'h8 : 4'ha, 8'h00, 8'h9d);
    end
    @(negedge clk_sys_in);
    check({7'h00, int_n_out}, 8'h01);
    cnt_saturated_in <= 4'h0;
    pulse(0);
    rd(4'ha, 8'h00, 8'h9d);
    pulse(10);
    @(negedge clk_sys_in);
    check({7'h00, int_n_out}, 8'h00);
    rd(4'h8, 8'h04, 8'h04, 1'b1);
    rd(4'h8, 8'h04, 8'h04);
    rd(4'h8, 8'h00, 8'h04);
    clk_en_in <= 1'b0;
    pulse(10);
    clk_en_in <= 1'b1;
    rd(4'h8, 8'h00, 8'h04);
    resync_active_in <= 1'b1;
    rd(4'h8, 8'h08, 8'h08);
    rd(4'h8, 8'h08, 8'h08);
    resync_active_in <= 1'b0;
    rd(4'h8, 8'h08, 8'h08);
    rd(4'h8, 8'h00, 8'h08);
    rd(4'h8, 8'h02, 8'h02);
    sends(1'b0, 7);
    rd(4'h8, 8'h00, 8'hc0);
    sends(1'b0, 1);
    rd(4'h8, 8'h80, 8'hc0);
    sends(1'b0, 8);
    rd(4'h8, 8'hc0, 8'he0);
    sends(1'b1, 1);
    rd(4'h8, 8'hc0, 8'he0);
    rd(4'h8, 8'h00, 8'he0);
    sends(1'b0, 191);
    rd(4'h8, 8'hc0, 8'he0);
    sends(1'b0, 1);
    rd(4'h8, 8'he0, 8'he0);
    sends(1'b1, 112);
    rd(4'ha, 8'h60, 8'h60);
    rd(4'h8, 8'he0, 8'he0);
    rd(4'h8, 8'h02, 8'he2);
    yel(0, 1'b0, 255);
    rd(4'h8, 8'h00, 8'h10);
    yel(0, 1'b0, 1);
    rd(4'h8, 8'h10, 8'h10);
    yel(0, 1'b1, 1);
    rd(4'h8, 8'h10, 8'h10);
    rd(4'h8, 8'h00, 8'h10);
    yellow_format_bit_in <= 1'b1;
    yel(1, 1'b1, 1);
    rd(4'h8, 8'h10, 8'h10);
    yel(1, 1'b0, 1);
    rd(4'h8, 8'h10, 8'h10);
    rd(4'h8, 8'h00, 8'h10);
    framing_mode_bit_in <= 1'b1;
    yel(2, 1'b1, 15);
    rd(4'h8, 8'h00, 8'h10);
    yel(2, 1'b1, 1);
    rd(4'h8, 8'h10, 8'h10);
    yel(2, 1'b0, 1);
    rd(4'h8, 8'h10, 8'h10);
    rd(4'h8, 8'h00, 8'h10);
    t1asi_host_model_inst.wr(4'h9, 8'h00);
    t1asi_host_model_inst.wr(4'hb, 8'h00);
    repeat (4) @(posedge clk_sys_in);
    stop_test();
  end
endmodule

`default_nettype wire
